// >>> bayer_demosaic_gain_bench.sv
// ==========================================
// self-checking bench for the demosaic stage
module bayer_demosaic_gain_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 6;
  localparam int H = 4;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rgb_valid_o, start;
  logic        pix_valid_i, pix_ready_o, pix_sof_i, pix_eol_i;
  logic        rgb_ready_i = 1'b0;
  logic [3:0]  wb_sel_i;
  logic [11:0] pix_data_i;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rnd, q;
  logic [31:0] rq = 32'h59EFD705;
  logic [7:0]  red_o, green_o, blue_o, rv, gv, bv, gr, gg, gb;
  logic [2:0]  osel;
  logic [1:0]  ph, dep;
  int          bad_count, checks_done;
  int          k = 0;
  int          fc = 0;

  demosaic_gain u_demosaic_gain (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .pix_data_i(pix_data_i), .pix_sof_i(pix_sof_i),
    .pix_eol_i(pix_eol_i), .rgb_valid_o(rgb_valid_o), .rgb_ready_i(rgb_ready_i), .red_o(red_o),
    .green_o(green_o), .blue_o(blue_o));
  camera_source #(.W(W), .H(H)) u_camera_source (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .phase_i(ph), .depth_i(dep), .red_i(rv), .green_i(gv),
    .blue_i(bv), .pix_valid_o(pix_valid_i), .pix_ready_i(pix_ready_o), .pix_data_o(pix_data_i),
    .pix_sof_o(pix_sof_i), .pix_eol_o(pix_eol_i));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr
  function automatic logic [7:0] gn(input logic [7:0] v, input logic [7:0] g);
    logic [15:0] p;
    p = ({8'h00, v} * {8'h00, g}) >> 6;
    return (p > 16'h00FF) ? 8'hFF : p[7:0];
  endfunction : gn
  // expected word at an interior position
  function automatic logic [23:0] exp_px(input int r, input int c);
    logic [2:0][7:0] m;
    logic [7:0]      raw, y;
    raw = (((r ^ c ^ ph[0]) & 1) == 1) ? gv : ((((r & 1) ^ ph[1]) & 1) == 1) ? rv : bv;
    y   = 8'((16'(rv) * 16'(demosaic_pkg::LUMA_R) + 16'(gv) * 16'(demosaic_pkg::LUMA_G)
            + 16'(bv) * 16'(demosaic_pkg::LUMA_B)) >> 8);
    case (osel)
      3'h0: m = {rv, gv, bv};
      3'h1: m = {3{raw}};
      3'h2: m = {3{y}};
      3'h3: m = {3{rv}};
      3'h4: m = {3{gv}};
      3'h5: m = {3{bv}};
      default: m = 24'h0;
    endcase
    return {gn(m[2], gr), gn(m[1], gg), gn(m[0], gb)};
  endfunction : exp_px

  task automatic chk_px(input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] pixel exp %h got %h", e, g);
    end
  endtask : chk_px
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk_reg
  // one classic bus cycle, read data left in q
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // no timeout here: the ack ends the wait, and only the watchdog ends one that gets no answer
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic stop_test;
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // watchdog
  initial
  begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end

  // downstream: random ready, long stall at frame start on half the frames
  always @(posedge clk_i)
  begin
    rq          <= lfsr(rq);
    fc          <= start ? 0 : fc + 1;
    rgb_ready_i <= (osel[1] && fc < 40) ? 1'b0 : (rq[1:0] != 2'h0);
    if (start)
      k <= 0;
    else if (!rst_i && rgb_valid_o === 1'b1 && rgb_ready_i === 1'b1)
    begin
      if (k / W > 0 && k % W > 0)
        chk_px(exp_px(k / W, k % W), {red_o, green_o, blue_o});
      k <= k + 1;
    end
  end

  // main sequence
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, start} = 5'h10;
    {wb_sel_i, wb_adr_i, wb_dat_i} = '0;
    {osel, ph, dep, rv, gv, bv, gr, gg, gb} = '0;
    rnd = 32'h59EFD705;
    bad_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 32'h0, 32'h0, 4'hF);
    chk_reg("ctrl reset", demosaic_pkg::CTRL_RESET, q);
    for (int t = 0; t < 32; t++)
    begin
      rnd = lfsr(rnd);
      osel <= 3'(t);
      ph   <= 2'(t >> 3);
      dep  <= 2'(t) ^ 2'(t >> 2);
      {rv, gv, bv} <= (t == 0) ? 24'hFFFFFF : rnd[23:0];
      rnd = lfsr(rnd);
      {gb, gg, gr} <= (t == 0) ? 24'hFFFFFF : (t == 1) ? 24'h0 : rnd[23:0];
      @(posedge clk_i);
      wb(1'b1, 32'h0, {ph, dep, 1'b1, osel, gb, gg, gr}, 4'hF);
      wb(1'b0, 32'h0, 32'h0, 4'hF);
      chk_reg("ctrl", {ph, dep, 1'b0, osel, gb, gg, gr}, q);
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      @(posedge clk_i);
      for (int n = 0; n < 2000 && k < W * H; n++)
        @(posedge clk_i);
      chk_reg("pixel count", 32'(W * H), 32'(k));
      wb(1'b1, 32'h4, 32'hFFFFFFFF, 4'hF);
      wb(1'b0, 32'h4, 32'h0, 4'hF);
      // drained buffer: no stall flag; even row count: parity back at zero
      chk_reg("status", {6'h00, 1'b0, 1'(H % 2), 8'(t + 1), 16'(H)}, q);
    end
    wb(1'b1, 32'h8, 32'hFFFFFFFF, 4'hF);
    wb(1'b1, 32'h0, 32'hFFFFFFFF, 4'h0);
    wb(1'b1, 32'h0, 32'h12345678, 4'h2);
    wb(1'b0, 32'h8, 32'h0, 4'hF);
    chk_reg("unmapped", 32'h0, q);
    wb(1'b0, 32'h0, 32'h0, 4'hF);
    chk_reg("ctrl lanes", {ph, dep, 1'b0, osel, gb, 8'h56, gr}, q);
    stop_test();
  end
endmodule : bayer_demosaic_gain_bench

bind demosaic_gain demosaic_gain_checker u_demosaic_gain_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_valid_i(pix_valid_i),
  .pix_ready_o(pix_ready_o), .rgb_valid_o(rgb_valid_o), .rgb_ready_i(rgb_ready_i), .red_o(red_o),
  .green_o(green_o), .blue_o(blue_o));

// >>> camera_source.sv
// ==========================================
// camera mosaic source, one frame per start
module camera_source #(
  parameter int W = 6,
  parameter int H = 4
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // frame setup
  input  wire logic       start_i,
  input  wire logic [1:0] phase_i,
  input  wire logic [1:0] depth_i,
  input  wire logic [7:0] red_i,
  input  wire logic [7:0] green_i,
  input  wire logic [7:0] blue_i,
  // mosaic stream
  output logic            pix_valid_o,
  input  wire logic       pix_ready_i,
  output logic [11:0]     pix_data_o,
  output logic            pix_sof_o,
  output logic            pix_eol_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        act, show;
  logic [31:0] rnd;
  logic [7:0]  v;
  logic [11:0] jk;
  int          r, c;

  // colour laid out from the sensor filter origin
  always_comb
  begin
    if (((r ^ c ^ phase_i[0]) & 1) == 1)
      v = green_i;
    else if ((((r & 1) ^ phase_i[1]) & 1) == 1)
      v = red_i;
    else
      v = blue_i;
    jk = 12'(r * 37 + c * 11) ^ 12'hA5C;
  end

  // value placed by width code, junk elsewhere, noise when idle
  assign pix_data_o  = !show ? rnd[11:0] : (depth_i == 2'h2) ? {jk[11:10], v, jk[1:0]}
                     : (depth_i == 2'h1) ? {v, jk[3:0]} : {jk[11:8], v};
  assign pix_valid_o = show;
  assign pix_sof_o   = show ? (r == 0 && c == 0) : rnd[12];
  assign pix_eol_o   = show ? (c == W - 1) : rnd[13];

  // walk the frame with random gaps, holding each pixel until taken
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      act  <= 1'b0;
      show <= 1'b0;
      rnd  <= 32'h1F2E3D4C;
    end
    else
    begin
      rnd <= {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      if (start_i)
      begin
        act  <= 1'b1;
        show <= 1'b0;
        r    <= 0;
        c    <= 0;
      end
      else if (act && (!show || pix_ready_i))
      begin
        show <= rnd[0] | rnd[1];
        if (show)
        begin
          c <= (c == W - 1) ? 0 : c + 1;
          r <= (c == W - 1) ? r + 1 : r;
          if (c == W - 1 && r == H - 1)
          begin
            act  <= 1'b0;
            show <= 1'b0;
          end
        end
      end
    end
  end
endmodule : camera_source

// >>> demosaic_gain.sv
// The register offsets and the Wishbone slave port were decided locally.
module demosaic_gain (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // mosaic pixel stream in
  input  wire logic        pix_valid_i,
  output logic             pix_ready_o,
  input  wire logic [11:0] pix_data_i,
  input  wire logic        pix_sof_i,
  input  wire logic        pix_eol_i,
  // colour stream out
  output logic             rgb_valid_o,
  input  wire logic        rgb_ready_i,
  output logic      [7:0]  red_o,
  output logic      [7:0]  green_o,
  output logic      [7:0]  blue_o
);

  // ==========================================================
  // register bus slave
  // ==========================================================
  logic [31:0] ctrl_reg;
  logic [31:0] status_word;
  logic        ack_reg;
  logic [31:0] rd_data_reg;
  logic        bus_req;
  logic        ctrl_hit;
  logic        status_hit;

  assign bus_req    = wb_cyc_i && wb_stb_i && !ack_reg;
  assign ctrl_hit   = (wb_adr_i[3:0] == demosaic_pkg::CTRL_OFFSET);
  assign status_hit = (wb_adr_i[3:0] == demosaic_pkg::STATUS_OFFSET);
  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = rd_data_reg;

  // one-cycle answer, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= bus_req;
    end
  end

  // read data, unmapped words read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_reg <= 32'h0000_0000;
    end
    else if (bus_req && !wb_we_i)
    begin
      if (ctrl_hit)
      begin
        rd_data_reg <= ctrl_reg;
      end
      else if (status_hit)
      begin
        rd_data_reg <= status_word;
      end
      else
      begin
        rd_data_reg <= 32'h0000_0000;
      end
    end
  end

  // control word, byte-lane writes, reserved bit held at zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= demosaic_pkg::CTRL_RESET;
    end
    else if (bus_req && wb_we_i && ctrl_hit)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (wb_sel_i[i])
        begin
          ctrl_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
        end
      end
      ctrl_reg[demosaic_pkg::RSVD_BIT] <= 1'b0;
    end
  end

  // control fields
  logic [7:0] gain [3];
  logic [2:0] out_sel;
  logic [1:0] bit_depth;
  logic [1:0] start_phase;

  assign gain[0]     = ctrl_reg[demosaic_pkg::RED_GAIN_LSB +: 8];
  assign gain[1]     = ctrl_reg[demosaic_pkg::GREEN_GAIN_LSB +: 8];
  assign gain[2]     = ctrl_reg[demosaic_pkg::BLUE_GAIN_LSB +: 8];
  assign out_sel     = ctrl_reg[demosaic_pkg::OUT_SEL_LSB +: 3];
  assign bit_depth   = ctrl_reg[demosaic_pkg::BIT_DEPTH_LSB +: 2];
  assign start_phase = ctrl_reg[demosaic_pkg::START_PHASE_LSB +: 2];

  // ==========================================================
  // input acceptance and pixel position
  // ==========================================================
  logic buf_in_ready;
  logic accept;

  assign pix_ready_o = buf_in_ready;
  assign accept      = pix_valid_i && buf_in_ready;

  // pixel scaled to 8 bits from its width code
  logic [7:0] cur_pix;

  always_comb
  begin
    case (bit_depth)
      demosaic_pkg::DEPTH_12: cur_pix = pix_data_i[11:4];
      demosaic_pkg::DEPTH_10: cur_pix = pix_data_i[9:2];
      demosaic_pkg::DEPTH_8:  cur_pix = pix_data_i[7:0];
      default:                cur_pix = pix_data_i[7:0];  // reserved code as 8-bit
    endcase
  end

  // column/row parity, start of frame forces the origin
  logic                          col_odd_reg;
  logic                          row_odd_reg;
  logic [demosaic_pkg::COL_W-1:0] col_reg;
  logic                          col_odd;
  logic                          row_odd;
  logic [demosaic_pkg::COL_W-1:0] col;

  assign col_odd = pix_sof_i ? 1'b0 : col_odd_reg;
  assign row_odd = pix_sof_i ? 1'b0 : row_odd_reg;
  assign col     = pix_sof_i ? '0 : col_reg;

  // position tracking
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      col_odd_reg <= 1'b0;
      row_odd_reg <= 1'b0;
      col_reg     <= '0;
    end
    else if (accept)
    begin
      if (pix_eol_i)
      begin
        col_odd_reg <= 1'b0;
        col_reg     <= '0;
        row_odd_reg <= ~row_odd;
      end
      else
      begin
        col_odd_reg <= ~col_odd;
        col_reg     <= col + {{(demosaic_pkg::COL_W-1){1'b0}}, 1'b1};
        row_odd_reg <= row_odd;
      end
    end
  end

  // ==========================================================
  // line store and neighbourhood
  // ==========================================================
  logic [7:0] line_mem [demosaic_pkg::LINE_MAX];
  logic [7:0] left_reg;
  logic [7:0] up_left_reg;
  logic [7:0] up_pix;

  assign up_pix = line_mem[col];

  // previous line kept one pixel per column
  always_ff @(posedge clk_i)
  begin
    if (accept)
    begin
      line_mem[col] <= cur_pix;
    end
  end

  // left and upper-left neighbours
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      left_reg    <= 8'h00;
      up_left_reg <= 8'h00;
    end
    else if (accept)
    begin
      left_reg    <= cur_pix;
      up_left_reg <= up_pix;
    end
  end

  // ==========================================================
  // colour reconstruction over a 2x2 window
  // ==========================================================
  logic       cur_green;
  logic       row_red;
  logic [8:0] green_sum;
  logic [7:0] rec_red;
  logic [7:0] rec_green;
  logic [7:0] rec_blue;

  // phase bit 0: green first; phase bit 1: first row carries red
  assign cur_green = col_odd ^ row_odd ^ start_phase[0];
  assign row_red   = row_odd ^ start_phase[1];

  // same-colour neighbours averaged or taken
  always_comb
  begin
    if (cur_green)
    begin
      green_sum = {1'b0, cur_pix} + {1'b0, up_left_reg};
      rec_green = green_sum[8:1];
      rec_red   = row_red ? left_reg : up_pix;
      rec_blue  = row_red ? up_pix : left_reg;
    end
    else
    begin
      green_sum = {1'b0, left_reg} + {1'b0, up_pix};
      rec_green = green_sum[8:1];
      rec_red   = row_red ? cur_pix : up_left_reg;
      rec_blue  = row_red ? up_left_reg : cur_pix;
    end
  end

  // fixed weighted intensity
  logic [15:0] luma_sum;
  logic [7:0]  luma;

  assign luma_sum = 16'(rec_red) * 16'(demosaic_pkg::LUMA_R)
                  + 16'(rec_green) * 16'(demosaic_pkg::LUMA_G)
                  + 16'(rec_blue) * 16'(demosaic_pkg::LUMA_B);
  assign luma     = luma_sum[15:8];

  // ==========================================================
  // output selector
  // ==========================================================
  logic [7:0] chan_val [3];

  always_comb
  begin
    case (out_sel)
      demosaic_pkg::SEL_RGB:
      begin
        chan_val[0] = rec_red;
        chan_val[1] = rec_green;
        chan_val[2] = rec_blue;
      end
      demosaic_pkg::SEL_RAW:
      begin
        chan_val[0] = cur_pix;
        chan_val[1] = cur_pix;
        chan_val[2] = cur_pix;
      end
      demosaic_pkg::SEL_INTENSITY:
      begin
        chan_val[0] = luma;
        chan_val[1] = luma;
        chan_val[2] = luma;
      end
      demosaic_pkg::SEL_RED:
      begin
        chan_val[0] = rec_red;
        chan_val[1] = rec_red;
        chan_val[2] = rec_red;
      end
      demosaic_pkg::SEL_GREEN:
      begin
        chan_val[0] = rec_green;
        chan_val[1] = rec_green;
        chan_val[2] = rec_green;
      end
      demosaic_pkg::SEL_BLUE:
      begin
        chan_val[0] = rec_blue;
        chan_val[1] = rec_blue;
        chan_val[2] = rec_blue;
      end
      default:
      begin
        chan_val[0] = 8'h00;       // reserved codes give black
        chan_val[1] = 8'h00;
        chan_val[2] = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // per-channel gain, scale by 64, saturate
  // ==========================================================
  logic [7:0] gained [3];

  generate
    for (genvar c = 0; c < 3; c++)
    begin : g_gain
      logic [15:0] product;
      logic [9:0]  scaled;

      // channel 0 red, 1 green, 2 blue
      assign product   = 16'(chan_val[c]) * 16'(gain[c]);
      assign scaled    = product[15:demosaic_pkg::GAIN_SHIFT];
      assign gained[c] = (|scaled[9:8]) ? demosaic_pkg::SAT_MAX : scaled[7:0];
    end
  endgenerate

  // ==========================================================
  // output buffer
  // ==========================================================
  logic [23:0] buf_out;

  pair_buffer #(
    .WIDTH (24)
  ) u_out_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (pix_valid_i),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({gained[0], gained[1], gained[2]}),
    .out_valid_o (rgb_valid_o),
    .out_ready_i (rgb_ready_i),
    .out_data_o  (buf_out)
  );

  assign red_o   = buf_out[23:16];
  assign green_o = buf_out[15:8];
  assign blue_o  = buf_out[7:0];

  // ==========================================================
  // status counters
  // ==========================================================
  logic [15:0] line_cnt_reg;
  logic [7:0]  frame_cnt_reg;

  // lines completed in current frame, frames started
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      line_cnt_reg  <= 16'h0000;
      frame_cnt_reg <= 8'h00;
    end
    else if (accept)
    begin
      if (pix_sof_i)
      begin
        frame_cnt_reg <= frame_cnt_reg + 8'h01;
        line_cnt_reg  <= pix_eol_i ? 16'h0001 : 16'h0000;
      end
      else if (pix_eol_i)
      begin
        line_cnt_reg <= line_cnt_reg + 16'h0001;
      end
    end
  end

  // status word assembly
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[demosaic_pkg::LINE_CNT_LSB +: 16] = line_cnt_reg;
    status_word[demosaic_pkg::FRAME_CNT_LSB +: 8] = frame_cnt_reg;
    status_word[demosaic_pkg::ROW_ODD_BIT]        = row_odd_reg;
    status_word[demosaic_pkg::OUT_STALL_BIT]      = !buf_in_ready;
  end

endmodule : demosaic_gain

// >>> demosaic_gain_checker.sv
// ==========================================
// port-level checks for the demosaic stage
module demosaic_gain_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // streams
  input wire logic        pix_valid_i,
  input wire logic        pix_ready_o,
  input wire logic        rgb_valid_o,
  input wire logic        rgb_ready_i,
  input wire logic [7:0]  red_o,
  input wire logic [7:0]  green_o,
  input wire logic [7:0]  blue_o
);
  logic [3:0] adr_q;
  logic       we_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // request as seen one edge back
  always_ff @(posedge clk_i)
  begin
    adr_q <= wb_adr_i[3:0];
    we_q  <= wb_we_i;
  end

  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i) && !$past(wb_ack_o);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_hold;
    !wb_ack_o |-> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved between reads");
  property p_unmapped;
    wb_ack_o && !we_q && adr_q != 4'h0 && adr_q != 4'h4 |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rsvd_bit;
    wb_ack_o && !we_q && adr_q == 4'h0 |-> !wb_dat_o[27];
  endproperty
  a_rsvd_bit: assert property (p_rsvd_bit) else $error("reserved control bit reads one");
  property p_out_hold;
    rgb_valid_o && !rgb_ready_i |=> rgb_valid_o && $stable({red_o, green_o, blue_o});
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output word changed before pop");
  property p_full_valid;
    !pix_ready_o |-> rgb_valid_o;
  endproperty
  a_full_valid: assert property (p_full_valid) else $error("input stalled with empty buffer");
  property p_fill_answer;
    pix_valid_i && pix_ready_o && !rgb_valid_o |=> rgb_valid_o;
  endproperty
  a_fill_answer: assert property (p_fill_answer) else $error("no output one cycle after pixel");
  property p_fill_count;
    pix_valid_i && pix_ready_o && rgb_valid_o && !rgb_ready_i |=> !pix_ready_o;
  endproperty
  a_fill_count: assert property (p_fill_count) else $error("buffer of two not full");
endmodule : demosaic_gain_checker

// >>> demosaic_pkg.sv
package demosaic_pkg;

  // ==========================================================
  // register map (byte offsets within the slave window)
  // ==========================================================
  localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET = 4'h4;

  // control word reset: unity gains, full colour, 8-bit, phase 0
  localparam logic [31:0] CTRL_RESET    = 32'h0040_4040;

  // control field positions
  localparam int RED_GAIN_LSB    = 0;
  localparam int GREEN_GAIN_LSB  = 8;
  localparam int BLUE_GAIN_LSB   = 16;
  localparam int OUT_SEL_LSB     = 24;
  localparam int RSVD_BIT        = 27;
  localparam int BIT_DEPTH_LSB   = 28;
  localparam int START_PHASE_LSB = 30;

  // status field positions
  localparam int LINE_CNT_LSB    = 0;
  localparam int FRAME_CNT_LSB   = 16;
  localparam int ROW_ODD_BIT     = 24;
  localparam int OUT_STALL_BIT   = 25;

  // output selector codes
  localparam logic [2:0] SEL_RGB       = 3'h0;
  localparam logic [2:0] SEL_RAW       = 3'h1;
  localparam logic [2:0] SEL_INTENSITY = 3'h2;
  localparam logic [2:0] SEL_RED       = 3'h3;
  localparam logic [2:0] SEL_GREEN     = 3'h4;
  localparam logic [2:0] SEL_BLUE      = 3'h5;

  // pixel width codes
  localparam logic [1:0] DEPTH_8  = 2'h0;
  localparam logic [1:0] DEPTH_12 = 2'h1;
  localparam logic [1:0] DEPTH_10 = 2'h2;

  // gain scale and saturation
  localparam int         GAIN_SHIFT = 6;
  localparam logic [7:0] SAT_MAX    = 8'hFF;

  // intensity weights, sum 256
  localparam logic [7:0] LUMA_R = 8'h4D;
  localparam logic [7:0] LUMA_G = 8'h96;
  localparam logic [7:0] LUMA_B = 8'h1D;

  // line store
  localparam int LINE_MAX = 2048;
  localparam int COL_W    = 11;

endpackage : demosaic_pkg

// >>> pair_buffer.sv
// two-entry buffer with valid/ready on both sides
module pair_buffer #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  logic [WIDTH-1:0] store_reg [2];
  logic             wr_ptr_reg;
  logic             rd_ptr_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  // honest full and empty
  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = store_reg[rd_ptr_reg];

  // entry storage
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      store_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
      begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 2'h1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

endmodule : pair_buffer
